/* File: verilog/i2m_consts.svh */
// Purpose: Offsets, bit positions and reset values of the two-wire master engine
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Definitions only
`ifndef I2M_CONSTS_SVH
`define I2M_CONSTS_SVH

`define I2M_OFF_CTRL      8'h00
`define I2M_OFF_STATUS    8'h04
`define I2M_OFF_DATA      8'h08
`define I2M_OFF_RATE      8'h0C

`define I2M_C_ENABLE      0
`define I2M_C_RX_GO       1
`define I2M_C_ACK_GO      2
`define I2M_C_STOP_GO     3
`define I2M_C_ACK_VALUE   4

`define I2M_S_BUF_FULL    0
`define I2M_S_WRITE_COLLISION_FLAG        1
`define I2M_S_ACK_RESULT  2
`define I2M_S_EVENT       3
`define I2M_S_BUS_COL     4
`define I2M_S_RX_OVF      5
`define I2M_S_START_SEEN  6
`define I2M_S_STOP_SEEN   7
`define I2M_S_BUS_FREE    8

`define I2M_RATE_RST      8'h09
`define I2M_BITS_DATA     4'h7
`define I2M_BITS_ACK      4'h8

`endif

/* File: verilog/i2m_pkg.sv */
// Purpose: Types shared by the two-wire master engine
// Assumes: Constants live in i2m_consts.svh
// Notes:   No state codes are fixed
package i2m_pkg;

   typedef enum logic [3:0] {
      ST_IDLE, ST_LOW, ST_RISE, ST_HIGH,
      ST_STOP_A, ST_STOP_B, ST_STOP_C, ST_STOP_D, ST_STOP_E, ST_STOP_F
   } i2m_state_t;

   typedef enum logic [1:0] {K_TX, K_RX, K_ACK} i2m_kind_t;

endpackage : i2m_pkg

/* File: verilog/i2m_engine.sv */
// Purpose: Master byte engine of a two-wire serial port behind an APB slave
// Assumes: Open-drain pins, sys_clk_i at 200 MHz, pins synchronised by two flops
// Notes:   Start and repeated-start generation are outside this block
`timescale 1ns/1ps
`default_nettype none
`include "i2m_consts.svh"

//Contract
// [RULE_01] Buffer-full on write, cleared after 8 bits
// [RULE_02] Write while shifting dropped, write-collision set
// [RULE_03] Software clears write-collision before next transmission
// [RULE_04] Acknowledge result 0 on ack, 1 on nack
// [RULE_05] Buffer write starts shifting, MSB first
// [RULE_06] Capture ack, event flag after ninth clock
// [RULE_07] Stop raises event only when complete
// [RULE_08] Go requests ignored unless idle
// [RULE_09] Receive: rollover toggles SCL, SDA shifted in
// [RULE_10] Eighth receive fall: copy, flag, hold, idle
// [RULE_11] Receive: reading buffer clears buffer-full
// [RULE_12] Overflow when byte completes with buffer full
// [RULE_13] Write during receive/ack/stop sets write-collision
// [RULE_14] Ack sequence: low, release, high period, low
// [RULE_15] Software sets ack value before ack sequence
// [RULE_16] Stop: SDA low, SCL up, SDA up, event
// [RULE_17] Reset disables port, abandons transfer
// [RULE_18] Reset clears seen flags; bus-free rule
// [RULE_19] Released one read as zero: collision, idle
// [RULE_20] Transmit collision: halt, clear full, release lines
// [RULE_21] Sequence collision: abort, release, clear request
// [RULE_22] After collision, event on stop; rewrite restarts
// [RULE_23] Baud period reloads from rate value
// [RULE_24] Counter waits until SCL really high
// [RULE_25] Event and collision flags clear by software
// [RULE_26] Arbitration lost via one SDA compare
module i2m_engine
   import i2m_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        reset_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic        scl_i,
   output logic             scl_o,
   output logic             scl_oe_o,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_o
);

   logic [1:0]  scl_sync;
   logic [1:0]  sda_sync;
   logic        scl_q;
   logic        sda_q;
   logic        port_en;
   logic        receive_go;
   logic        ack_go;
   logic        stop_go;
   logic        ack_value_bit;
   logic [7:0]  rate_reload_value;
   logic        buffer_full_flag;
   logic        write_collision_flag;
   logic        ack_result_bit;
   logic        transfer_event_flag;
   logic        bus_collision_flag;
   logic        receive_overflow_flag;
   logic        start_seen;
   logic        stop_seen;
   logic        rx_mode;
   logic        arb_lost;
   logic [7:0]  data_buffer;
   logic [7:0]  shift_reg;
   logic [3:0]  bitcnt;
   logic [7:0]  cnt;
   i2m_state_t  state;
   i2m_state_t  next_state;
   i2m_kind_t   kind;
   logic        scl_low;
   logic        sda_low;

   // Pin sampling and bus condition detection
   wire scl_s     = scl_sync[1];
   wire sda_s     = sda_sync[1];
   wire start_det = scl_s & scl_q & sda_q & ~sda_s;
   wire stop_det  = scl_s & scl_q & ~sda_q & sda_s;

   // APB decode
   wire acc       = psel_i & penable_i;
   wire wr        = acc & pwrite_i;
   wire rd        = acc & ~pwrite_i;
   wire sel_ctrl  = paddr_i == `I2M_OFF_CTRL;
   wire sel_stat  = paddr_i == `I2M_OFF_STATUS;
   wire sel_data  = paddr_i == `I2M_OFF_DATA;
   wire sel_rate  = paddr_i == `I2M_OFF_RATE;
   wire mapped    = sel_ctrl | sel_stat | sel_data | sel_rate;
   wire idle      = state == ST_IDLE;
   wire bus_free  = stop_seen | (~start_seen & ~stop_seen);

   // [RULE_02] [RULE_13] busy write check
   wire dat_wr    = wr & sel_data & port_en;
   wire tx_go     = dat_wr & idle;
   wire write_collision_flag_set  = dat_wr & ~idle;
   // [RULE_08] go bits accepted only when idle
   wire go_ok     = wr & sel_ctrl & port_en & idle;
   wire rx_req    = go_ok & pwdata_i[`I2M_C_RX_GO];
   wire ack_req   = go_ok & ~rx_req & pwdata_i[`I2M_C_ACK_GO];
   wire stop_req  = go_ok & ~rx_req & ~ack_req & pwdata_i[`I2M_C_STOP_GO];
   wire stat_clr  = wr & sel_stat;
   wire rd_data   = rd & sel_data;

   // [RULE_23] baud period ends when the reloaded count reaches zero
   wire tick      = cnt == 8'h00;
   wire in_high   = state == ST_HIGH;
   wire rise_ok   = (state == ST_RISE) & scl_s;
   wire last_bit  = (kind == K_TX  & bitcnt == `I2M_BITS_ACK) |
                    (kind == K_RX  & bitcnt == `I2M_BITS_DATA) |
                    (kind == K_ACK);
   wire expect_one = (kind == K_TX & bitcnt < `I2M_BITS_ACK & shift_reg[7]) |
                     (kind == K_ACK & ack_value_bit);

   // [RULE_19] [RULE_26] released SDA read low while SCL high
   wire col_bit   = in_high & expect_one & ~sda_s;
   wire col_stop  = ((state == ST_STOP_D | state == ST_STOP_E) & ~scl_s) |
                    (state == ST_STOP_E & tick & ~sda_s);
   wire collide   = port_en & (col_bit | col_stop);
   wire bit_end   = in_high & tick & ~collide;
   wire tx_end    = bit_end & kind == K_TX & bitcnt == `I2M_BITS_ACK;
   wire tx_sent   = bit_end & kind == K_TX & bitcnt == `I2M_BITS_DATA;
   wire rx_end    = bit_end & kind == K_RX & bitcnt == `I2M_BITS_DATA;
   wire ack_end   = bit_end & kind == K_ACK;
   wire stop_end  = (state == ST_STOP_F) & tick;
   // [RULE_22] a stop seen after lost arbitration raises the event
   wire event_set = tx_end | rx_end | ack_end | stop_end | (arb_lost & stop_det);
   wire cnt_load  = next_state != state;

   // APB answers in the access cycle
   assign pready_o  = 1'b1;
   assign pslverr_o = acc & ~mapped;
   assign prdata_o  = ~rd ? 32'h0000_0000 :
      sel_ctrl ? {27'h0, ack_value_bit, stop_go, ack_go, receive_go, port_en} :
      sel_stat ? {23'h0, bus_free, stop_seen, start_seen, receive_overflow_flag,
                  bus_collision_flag, transfer_event_flag, ack_result_bit,
                  write_collision_flag, buffer_full_flag} :
      sel_data ? {24'h0, data_buffer} :
      sel_rate ? {24'h0, rate_reload_value} : 32'h0000_0000;

   // Open-drain pins only ever pull low
   assign scl_o    = 1'b0;
   assign sda_o    = 1'b0;
   assign scl_oe_o = scl_low;
   assign sda_oe_o = sda_low;

   always_ff @(posedge sys_clk_i) begin
      scl_sync <= {scl_sync[0], scl_i};
      sda_sync <= {sda_sync[0], sda_i};
      scl_q    <= scl_s;
      sda_q    <= sda_s;
   end

   always_comb begin
      next_state = state;
      if (~port_en | collide) begin
         next_state = ST_IDLE;
      end else begin
         case (state)
            ST_IDLE:   if (tx_go | rx_req | ack_req) next_state = ST_LOW;
                       else if (stop_req) next_state = ST_STOP_A;
            ST_LOW:    if (tick) next_state = ST_RISE;
            ST_RISE:   if (scl_s) next_state = ST_HIGH;
            ST_HIGH:   if (tick) next_state = last_bit ? ST_IDLE : ST_LOW;
            ST_STOP_A: if (~sda_s) next_state = ST_STOP_B;
            ST_STOP_B: if (tick) next_state = ST_STOP_C;
            ST_STOP_C: if (scl_s) next_state = ST_STOP_D;
            ST_STOP_D: if (tick) next_state = ST_STOP_E;
            ST_STOP_E: if (sda_s & scl_s) next_state = ST_STOP_F;
            ST_STOP_F: if (tick) next_state = ST_IDLE;
            default:   next_state = ST_IDLE;
         endcase
      end
   end

   // [RULE_24] counter frozen in the SCL rise-wait states ST_RISE and ST_STOP_C, reloaded on every step
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         cnt <= 8'h00;
      end else if (cnt_load) begin
         cnt <= rate_reload_value;
      end else if (cnt != 8'h00 && state != ST_RISE && state != ST_STOP_C) begin
         cnt <= cnt - 8'h01;
      end
   end

   // [RULE_17] reset or disable abandons the sequence
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         state <= ST_IDLE;
         kind  <= K_TX;
      end else begin
         state <= next_state;
         if (tx_go) begin
            kind <= K_TX;
         end else if (rx_req) begin
            kind <= K_RX;
         end else if (ack_req) begin
            kind <= K_ACK;
         end
      end
   end

   // [RULE_05] [RULE_09] bit counter and shifter
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         bitcnt    <= 4'h0;
         shift_reg <= 8'h00;
      end else begin
         if (idle) begin
            bitcnt <= 4'h0;
         end else if (bit_end & ~last_bit) begin
            bitcnt <= bitcnt + 4'h1;
         end
         if (tx_go) begin
            shift_reg <= pwdata_i[7:0];
         end else if (bit_end & kind == K_TX) begin
            shift_reg <= {shift_reg[6:0], 1'b0};
         end else if (rise_ok & kind == K_RX) begin
            shift_reg <= {shift_reg[6:0], sda_s};
         end
      end
   end

   // [RULE_14] [RULE_16] [RULE_20] [RULE_21] pin drive per step
   always_ff @(posedge sys_clk_i) begin
      if (reset_i | ~port_en | collide) begin
         scl_low <= 1'b0;
         sda_low <= 1'b0;
      end else begin
         case (next_state)
            ST_LOW:    scl_low <= 1'b1;
            ST_RISE,
            ST_HIGH:   scl_low <= 1'b0;
            ST_STOP_A,
            ST_STOP_B: scl_low <= 1'b1;
            ST_IDLE:   scl_low <= stop_end ? 1'b0 : scl_low | ~idle;
            default:   scl_low <= 1'b0;
         endcase
         if (state == ST_LOW) begin
            sda_low <= (kind == K_TX & bitcnt < `I2M_BITS_ACK & ~shift_reg[7]) |
                       (kind == K_ACK & ~ack_value_bit);
         end else if (state == ST_STOP_A) begin
            sda_low <= 1'b1;
         end else if (state == ST_STOP_D & tick) begin
            sda_low <= 1'b0;
         end
      end
   end

   // Control register; request bits drop when their sequence ends or aborts
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         port_en           <= 1'b0;
         ack_value_bit     <= 1'b0;
         rate_reload_value <= `I2M_RATE_RST;
      end else begin
         if (wr & sel_ctrl) begin
            port_en       <= pwdata_i[`I2M_C_ENABLE];
            ack_value_bit <= pwdata_i[`I2M_C_ACK_VALUE];
         end
         if (wr & sel_rate) begin
            rate_reload_value <= pwdata_i[7:0];
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i | ~port_en | collide) begin
         receive_go <= 1'b0;
         ack_go     <= 1'b0;
         stop_go    <= 1'b0;
      end else begin
         // [RULE_10] receive request clears at eighth fall
         receive_go <= rx_req | (receive_go & ~rx_end);
         ack_go     <= ack_req | (ack_go & ~ack_end);
         // [RULE_07] stop request clears with the completion event
         stop_go    <= stop_req | (stop_go & ~stop_end);
      end
   end

   // Status flags; a hardware set wins over a software clear
   always_ff @(posedge sys_clk_i) begin
      if (reset_i | ~port_en) begin
         buffer_full_flag      <= 1'b0;
         write_collision_flag  <= 1'b0;
         ack_result_bit        <= 1'b0;
         transfer_event_flag   <= 1'b0;
         bus_collision_flag    <= 1'b0;
         receive_overflow_flag <= 1'b0;
         start_seen            <= 1'b0;
         stop_seen             <= 1'b0;
         rx_mode               <= 1'b0;
         arb_lost              <= 1'b0;
         data_buffer           <= 8'h00;
      end else begin
         // [RULE_01] [RULE_11] [RULE_20] buffer-full set and clear
         if (tx_go | rx_end) begin
            buffer_full_flag <= 1'b1;
         end else if (tx_sent | (col_bit & kind == K_TX) | (rd_data & rx_mode)) begin
            buffer_full_flag <= 1'b0;
         end
         // [RULE_02] [RULE_13] collision on busy write
         if (write_collision_flag_set) begin
            write_collision_flag <= 1'b1;
         end else if (stat_clr & pwdata_i[`I2M_S_WRITE_COLLISION_FLAG]) begin
            write_collision_flag <= 1'b0;
         end
         // [RULE_04] [RULE_06] acknowledge captured at ninth rise
         if (rise_ok & kind == K_TX & bitcnt == `I2M_BITS_ACK) begin
            ack_result_bit <= sda_s;
         end
         // [RULE_25] sticky until software clears
         if (event_set) begin
            transfer_event_flag <= 1'b1;
         end else if (stat_clr & pwdata_i[`I2M_S_EVENT]) begin
            transfer_event_flag <= 1'b0;
         end
         if (collide) begin
            bus_collision_flag <= 1'b1;
         end else if (stat_clr & pwdata_i[`I2M_S_BUS_COL]) begin
            bus_collision_flag <= 1'b0;
         end
         // [RULE_12] overflow on second unread byte
         if (rx_end & buffer_full_flag) begin
            receive_overflow_flag <= 1'b1;
         end else if (stat_clr & pwdata_i[`I2M_S_RX_OVF]) begin
            receive_overflow_flag <= 1'b0;
         end
         // [RULE_18] start and stop tracking
         if (start_det) begin
            start_seen <= 1'b1;
            stop_seen  <= 1'b0;
         end else if (stop_det) begin
            start_seen <= 1'b0;
            stop_seen  <= 1'b1;
         end
         if (tx_go | rx_req) begin
            rx_mode <= rx_req;
         end
         // [RULE_22] lost state held until a stop or a fresh write
         if (collide) begin
            arb_lost <= 1'b1;
         end else if (stop_det | tx_go) begin
            arb_lost <= 1'b0;
         end
         if (tx_go) begin
            data_buffer <= pwdata_i[7:0];
         end else if (rx_end) begin
            data_buffer <= shift_reg;
         end
      end
   end

   sequence s_ack_high_done;
      state == ST_IDLE ##0 ~ack_go & scl_oe_o;
   endsequence

   sequence s_stop_finish;
      transfer_event_flag & ~stop_go ##0 state == ST_IDLE & ~scl_oe_o & ~sda_oe_o;
   endsequence

   chk_bf_on_write: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RULE_01]
      tx_go |=> buffer_full_flag ##0 data_buffer == $past(pwdata_i[7:0]))
      else $error("buffer-full not set on write");

   chk_write_collision_flag_keep: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RULE_02]
      write_collision_flag_set & ~rx_end |=> write_collision_flag & data_buffer == $past(data_buffer))
      else $error("busy write not refused");

   chk_ack_capture: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RULE_04]
      rise_ok & kind == K_TX & bitcnt == `I2M_BITS_ACK & port_en
      |=> ack_result_bit == $past(sda_s))
      else $error("acknowledge result wrong");

   chk_tx_event: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RULE_06]
      tx_end & port_en |=> transfer_event_flag & state == ST_IDLE & scl_low)
      else $error("no event after ninth clock");

   chk_rx_finish: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RULE_10]
      rx_end & port_en |=> ~receive_go & buffer_full_flag & data_buffer == $past(shift_reg)
      & scl_oe_o & state == ST_IDLE)
      else $error("receive end steps missing");

   chk_rx_overflow: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RULE_12]
      rx_end & port_en & buffer_full_flag |=> receive_overflow_flag)
      else $error("overflow not flagged");

   chk_rise_hold: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RULE_24]
      state == ST_RISE & ~scl_s & port_en & ~collide |=> state == ST_RISE & $stable(cnt))
      else $error("counter ran while SCL low");

   chk_collide_idle: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RULE_19]
      collide |=> bus_collision_flag & state == ST_IDLE & ~scl_oe_o & ~sda_oe_o)
      else $error("collision not handled");

   chk_ack_seq: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RULE_14]
      ack_end & port_en |=> s_ack_high_done)
      else $error("ack sequence end wrong");

   chk_stop_end: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RULE_16]
      stop_end & port_en |=> s_stop_finish)
      else $error("stop end wrong");

   chk_flag_sticky: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RULE_25]
      bus_collision_flag & port_en & ~(stat_clr & pwdata_i[`I2M_S_BUS_COL])
      |=> bus_collision_flag)
      else $error("collision flag dropped by hardware");

   chk_busy_go: assert property (@(posedge sys_clk_i) disable iff (reset_i) // [RULE_08]
      ~idle & ~receive_go & port_en & ~collide |=> ~receive_go)
      else $error("receive go taken while busy");

endmodule : i2m_engine
`default_nettype wire

/* File: sim/i2m_slave_model.sv */
// Purpose: Far-side slave on the two-wire bus for the engine bench
// Assumes: Bench resolves open-drain wires; sys_clk_i samples them
// Notes:   arm_i restarts bit counting; mode 0 listens, 1 sends, 2 fights bit one, 3 silent
`timescale 1ns/1ps
`default_nettype none
module i2m_slave_model (
   input  wire logic       sys_clk_i,
   input  wire logic       arm_i,
   input  wire logic [1:0] mode_i,
   input  wire logic       ack_i,
   input  wire logic [7:0] tx_byte_i,
   input  wire logic [3:0] stretch_i,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            scl_low_o,
   output logic            sda_low_o,
   output logic [7:0]      rx_byte_o
);
   logic       scl_q;
   logic [3:0] bitn;
   logic [3:0] hold;
   always @(posedge sys_clk_i) begin
      scl_q <= scl_i;
      // A clock still high at arm owes one fall before the first bit
      if (arm_i) begin
         bitn <= scl_i ? 4'hF : 4'h0;
         hold <= 4'h0;
      end else if (scl_q && !scl_i) begin
         bitn <= bitn + 4'h1;
         hold <= stretch_i;
      end else if (hold != 4'h0) begin
         hold <= hold - 4'h1;
      end
      // Every rising clock shifts the line level in
      if (!scl_q && scl_i) begin
         rx_byte_o <= {rx_byte_o[6:0], sda_i};
      end
   end
   // Stretching holds the clock low after each fall
   assign scl_low_o = (hold != 4'h0);
   // Acknowledge, send MSB first, or pull a released one low
   assign sda_low_o = (mode_i == 2'h0) ? (ack_i && bitn == 4'h8)
                    : (mode_i == 2'h1) ? (bitn < 4'h8 && !tx_byte_i[3'h7 - bitn[2:0]])
                    : (mode_i == 2'h2) && (bitn == 4'h0);
endmodule : i2m_slave_model
`default_nettype wire

/* File: sim/i2c_master_transfer_engine_tb_top.sv */
// Purpose: Self-checking bench of the two-wire master engine
// Assumes: Zero-wait APB slave, RATE set to 3 for short bit times
// Notes:   Status polled over APB; slave model drives the far side
`timescale 1ns/1ps
`default_nettype none
`include "i2m_consts.svh"
module i2c_master_transfer_engine_tb_top;
   logic        clk;
   logic        rst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        scl_o;
   logic        scl_oe;
   logic        sda_o;
   logic        sda_oe;
   logic        s_scl_low;
   logic        s_sda_low;
   logic        arm;
   logic        ack;
   logic [1:0]  mode;
   logic [7:0]  tx_byte;
   logic [7:0]  rx_byte;
   logic [3:0]  stretch;
   logic [31:0] rd;
   logic        err;
   int          n_mismatch;
   int          total_checks;
   int          cycles;
   wire         scl = !(scl_oe || s_scl_low);
   wire         sda = !(sda_oe || s_sda_low);

   i2m_engine u_i2m_engine (.sys_clk_i(clk), .reset_i(rst), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .scl_i(scl), .scl_o(scl_o), .scl_oe_o(scl_oe),
      .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe));
   i2m_slave_model u_i2m_slave_model (.sys_clk_i(clk), .arm_i(arm), .mode_i(mode), .ack_i(ack),
      .tx_byte_i(tx_byte), .stretch_i(stretch), .scl_i(scl), .sda_i(sda),
      .scl_low_o(s_scl_low), .sda_low_o(s_sda_low), .rx_byte_o(rx_byte));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         n_mismatch++;
         test_done();
      end
   end

   task automatic test_done();
      $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : test_done

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wait_flag(input int b);
      int n;
      n = 0;
      do begin
         apb(1'b0, `I2M_OFF_STATUS, 32'h0);
         n++;
      end while (rd[b] !== 1'b1 && n < 300);
      chk("status flag", 32'h1, {31'h0, rd[b]});
   endtask : wait_flag

   task automatic setup(input logic [1:0] m, input logic a, input logic [7:0] t,
                        input logic [3:0] s);
      @(posedge clk);
      mode    <= m;
      ack     <= a;
      tx_byte <= t;
      stretch <= s;
      arm     <= 1'b1;
      @(posedge clk);
      arm     <= 1'b0;
   endtask : setup

   task automatic t_regs();
      apb(1'b0, `I2M_OFF_STATUS, 32'h0);
      chk("status reset", 32'h100, rd); // Bus free
      apb(1'b0, `I2M_OFF_RATE, 32'h0);
      chk("rate reset", 32'h9, rd); // Reload
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, err});
      apb(1'b1, `I2M_OFF_RATE, 32'h3);
      apb(1'b1, `I2M_OFF_CTRL, 32'h1);
      $display("test regs done");
   endtask : t_regs

   task automatic t_tx(input logic [7:0] b, input logic a, input logic [3:0] s);
      setup(2'h0, a, 8'h00, s);
      apb(1'b1, `I2M_OFF_DATA, {24'h0, b});
      apb(1'b0, `I2M_OFF_STATUS, 32'h0);
      chk("full on write", 32'h1, {31'h0, rd[`I2M_S_BUF_FULL]}); // Set
      apb(1'b1, `I2M_OFF_DATA, 32'hFF);
      apb(1'b1, `I2M_OFF_CTRL, 32'h3);
      wait_flag(`I2M_S_EVENT); // Ninth clock
      repeat (40) @(posedge clk);
      apb(1'b0, `I2M_OFF_STATUS, 32'h0);
      chk("tx status", {28'h0, 1'b1, !a, 2'b10}, {26'h0, rd[5:0]}); // Flags
      chk("bus byte", {24'h0, b[6:0], !a}, {24'h0, rx_byte}); // MSB first
      apb(1'b0, `I2M_OFF_CTRL, 32'h0);
      chk("ctrl after tx", 32'h1, rd); // Go ignored
      chk("scl held", 32'h1, {31'h0, scl_oe}); // Held low
      apb(1'b1, `I2M_OFF_STATUS, 32'h3A); // Clear first
      apb(1'b0, `I2M_OFF_STATUS, 32'h0);
      chk("flags cleared", 32'h0, {26'h0, rd[5:3], 1'b0, rd[1:0]}); // Software
      $display("test tx done");
   endtask : t_tx

   task automatic t_rx(input logic [7:0] b, input logic ovf, input logic rd_it);
      setup(2'h1, 1'b0, b, 4'h0);
      apb(1'b1, `I2M_OFF_CTRL, 32'h3);
      apb(1'b1, `I2M_OFF_DATA, 32'h11);
      wait_flag(`I2M_S_EVENT);
      chk("rx status", {26'h0, ovf, 5'b01011}, {26'h0, rd[5:3], 1'b0, rd[1:0]});
      apb(1'b0, `I2M_OFF_CTRL, 32'h0);
      chk("rx go cleared", 32'h1, rd); // Self clear
      chk("scl held", 32'h1, {31'h0, scl_oe}); // Held low
      if (rd_it) begin
         apb(1'b0, `I2M_OFF_DATA, 32'h0);
         if (!ovf) begin
            chk("rx byte", {24'h0, b}, rd); // Shifted
         end
         apb(1'b0, `I2M_OFF_STATUS, 32'h0);
         chk("full read", 32'h0, {31'h0, rd[`I2M_S_BUF_FULL]}); // Read clears
      end
      apb(1'b1, `I2M_OFF_STATUS, 32'h3A);
      $display("test rx done");
   endtask : t_rx

   task automatic t_ack(input logic v);
      setup(2'h3, 1'b0, 8'h00, 4'h0);
      apb(1'b1, `I2M_OFF_CTRL, {27'h0, v, 4'h5}); // Value set first
      wait_flag(`I2M_S_EVENT);
      chk("ack level", {31'h0, v}, {31'h0, rx_byte[0]}); // Ack value
      apb(1'b0, `I2M_OFF_CTRL, 32'h0);
      chk("ack go cleared", {27'h0, v, 4'h1}, rd); // Self clear
      chk("scl low", 32'h1, {31'h0, scl_oe}); // Ends low
      apb(1'b1, `I2M_OFF_STATUS, 32'h3A);
      $display("test ack done");
   endtask : t_ack

   task automatic t_stop();
      setup(2'h3, 1'b0, 8'h00, 4'h0);
      apb(1'b1, `I2M_OFF_CTRL, 32'h9);
      wait_flag(`I2M_S_EVENT); // After stop
      chk("stop seen", 32'h3, {30'h0, rd[8:7]}); // Free
      chk("lines high", 32'h3, {30'h0, scl, sda}); // Released
      apb(1'b1, `I2M_OFF_CTRL, 32'h0);
      apb(1'b0, `I2M_OFF_STATUS, 32'h0);
      chk("disable seen", 32'h100, rd); // Cleared
      apb(1'b1, `I2M_OFF_CTRL, 32'h1);
      $display("test stop done");
   endtask : t_stop

   task automatic t_col();
      setup(2'h2, 1'b0, 8'h00, 4'h0);
      apb(1'b1, `I2M_OFF_DATA, 32'h80);
      wait_flag(`I2M_S_BUS_COL); // Lost one
      chk("col full", 32'h0, {31'h0, rd[`I2M_S_BUF_FULL]}); // Cleared
      chk("col released", 32'h0, {30'h0, scl_oe, sda_oe}); // Released
      setup(2'h3, 1'b0, 8'h00, 4'h0);
      wait_flag(`I2M_S_EVENT); // Stop seen
      apb(1'b1, `I2M_OFF_STATUS, 32'h3A);
      $display("test collision done");
      t_tx(8'h80, 1'b1, 4'h0); // Restart
   endtask : t_col

   task automatic t_rst();
      setup(2'h0, 1'b1, 8'h00, 4'h0);
      apb(1'b1, `I2M_OFF_DATA, 32'h55);
      repeat (12) @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      chk("reset lines", 32'h0, {28'h0, scl_o, sda_o, scl_oe, sda_oe}); // Abandoned
      apb(1'b0, `I2M_OFF_CTRL, 32'h0);
      chk("reset disable", 32'h0, rd); // Disabled
      apb(1'b0, `I2M_OFF_STATUS, 32'h0);
      chk("reset status", 32'h100, rd); // Seen clear
      $display("test reset done");
   endtask : t_rst

   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      arm = 1'b1;
      mode = 2'h3;
      ack = 1'b0;
      tx_byte = 8'h00;
      stretch = 4'h0;
      cycles = 0;
      n_mismatch = 0;
      total_checks = 0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_tx(8'hA5, 1'b1, 4'h0);
      t_tx(8'h3C, 1'b0, 4'h6);
      t_rx(8'h5A, 1'b0, 1'b1);
      t_rx(8'hC3, 1'b0, 1'b0);
      t_rx(8'h96, 1'b1, 1'b1);
      t_ack(1'b0);
      t_ack(1'b1);
      t_stop();
      t_col();
      t_rst();
      test_done();
   end
endmodule : i2c_master_transfer_engine_tb_top
`default_nettype wire
